// [pfc_flash_host.sv]
// How it works
// - three command writes open every sector program
// - load: strobe low pulse, select low, enable high
// - next load falls within 150 us window
// - sector address steady, bytes any order
// - host waits for completion before next access
// - seven command writes lock a boot block
// - hardware id: high voltage pin, bit 0 selects
`include "pfc_defs.svh"
module pfc_flash_host #(
    parameter int PROG_TIMEOUT_CYC = `PFC_PROG_CYC,
    parameter int WE_LOW_CYC = `PFC_WE_LOW_CYC,
    parameter logic [16:0] CMD_ADDR_A = 17'h00aaa,
    parameter logic [16:0] CMD_ADDR_B = 17'h00555,
    parameter logic [7:0] CMD_DATA_A = 8'h11,
    parameter logic [7:0] CMD_DATA_B = 8'h22,
    parameter logic [7:0] CODE_PROG = 8'h33,
    parameter logic [7:0] CODE_ERASE = 8'h44,
    parameter logic [7:0] CODE_ERASE_FINAL = 8'h55,
    parameter logic [7:0] CODE_LOCK = 8'h66,
    parameter logic [7:0] CODE_LOCK_FINAL = 8'h77,
    parameter logic [7:0] CODE_ID_ENTRY = 8'h88,
    parameter logic [7:0] CODE_ID_EXIT = 8'h99
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clkEn,
    // sector buffer fill
    input wire logic fillValid,
    output logic fillReady,
    input wire logic [6:0] fillIndex,
    input wire logic [7:0] fillData,
    // request and answer
    input wire logic reqValid,
    output logic reqReady,
    input wire pfc_pkg::pfc_req_t req,
    output logic rspValid,
    output pfc_pkg::pfc_rsp_t rsp,
    // flash pins
    output pfc_pkg::pfc_pins_t pins,
    input wire logic [7:0] dataIn
);
    // ----------------------------------------
    // cycle counts of one bus access
    // ----------------------------------------
    localparam int WR_END = WE_LOW_CYC + 2;
    localparam int RD_SAMPLE = `PFC_ACCESS_CYC + `PFC_SYNC_CYC + 1;
    localparam int RD_END = RD_SAMPLE + 1;
    localparam int TW = $clog2(PROG_TIMEOUT_CYC + 1);

    // refuse settings the sequencer cannot serve
    if (WE_LOW_CYC < 1 || WE_LOW_CYC * `PFC_CLK_NS <= `PFC_GLITCH_NS) begin : g_chk_pulse
        $error("write strobe pulse too short");
    end
    if ((WR_END + 1) * 2 >= `PFC_LOAD_WINDOW_CYC) begin : g_chk_window
        $error("byte load spacing exceeds load window");
    end
    if (PROG_TIMEOUT_CYC < 2) begin : g_chk_timeout
        $error("program timeout too short");
    end

    typedef enum logic [2:0] {S_IDLE, S_CMD, S_LOAD, S_POLL, S_READ, S_RESP} pfc_state_t;

    // ----------------------------------------
    // state
    // ----------------------------------------
    pfc_state_t state_r, state_nxt;
    pfc_pkg::pfc_req_t req_r; // latched request
    logic [3:0] cnt_r; // phase within one access
    logic [2:0] step_r; // command write index
    logic [6:0] idx_r; // byte within sector
    logic [7:0] lastData_r; // last loaded byte
    logic [7:0] prevRead_r; // previous polling read
    logic havePrev_r; // a polling read already taken
    logic [TW-1:0] tmo_r; // polling time budget
    logic [7:0] memData; // buffered byte for current index
    logic [7:0] pinData; // filtered data pins
    pfc_pkg::pfc_pins_t pinsNxt;

    // ----------------------------------------
    // command sequence decode
    // ----------------------------------------
    // length of the command prefix of an operation
    function automatic logic [2:0] seqLen(input pfc_pkg::pfc_op_t op);
        case (op)
            pfc_pkg::PFC_OP_CHIP_ERASE: seqLen = 3'h6;
            pfc_pkg::PFC_OP_LOCK_LOW, pfc_pkg::PFC_OP_LOCK_HIGH: seqLen = 3'h7;
            default: seqLen = 3'h3;
        endcase
    endfunction

    // address and data of one command write
    function automatic pfc_pkg::pfc_wr_t seqWord(input pfc_pkg::pfc_op_t op,
                                                 input logic [2:0] step);
        logic [7:0] code;
        logic isLock;
        isLock = (op == pfc_pkg::PFC_OP_LOCK_LOW) || (op == pfc_pkg::PFC_OP_LOCK_HIGH);
        case (op)
            pfc_pkg::PFC_OP_PROGRAM: code = CODE_PROG;
            pfc_pkg::PFC_OP_CHIP_ERASE: code = (step < 3'h3) ? CODE_ERASE : CODE_ERASE_FINAL;
            pfc_pkg::PFC_OP_ID_ENTRY: code = CODE_ID_ENTRY;
            pfc_pkg::PFC_OP_ID_EXIT: code = CODE_ID_EXIT;
            default: code = CODE_LOCK;
        endcase
        if (isLock && step == 3'h6) begin
            // last lock write names the block
            seqWord.addr = (op == pfc_pkg::PFC_OP_LOCK_LOW) ?
                           `PFC_BOOT_LO_BASE : `PFC_BOOT_HI_BASE;
            seqWord.data = CODE_LOCK_FINAL;
        end else if (step == 3'h0 || step == 3'h3) begin
            seqWord.addr = CMD_ADDR_A;
            seqWord.data = CMD_DATA_A;
        end else if (step == 3'h1 || step == 3'h4) begin
            seqWord.addr = CMD_ADDR_B;
            seqWord.data = CMD_DATA_B;
        end else begin
            seqWord.addr = CMD_ADDR_A;
            seqWord.data = code;
        end
    endfunction

    // ----------------------------------------
    // named decode wires
    // ----------------------------------------
    wire pfc_pkg::pfc_wr_t cmdWord = seqWord(req_r.op, step_r);
    wire [16:0] loadAddr = {req_r.addr[16:`PFC_SECTOR_LSB], idx_r};
    wire [16:0] pollAddr = (req_r.op == pfc_pkg::PFC_OP_PROGRAM) ? loadAddr : req_r.addr;
    wire isWrite = (state_r == S_CMD) || (state_r == S_LOAD);
    wire isRead = (state_r == S_POLL) || (state_r == S_READ);
    wire wrDone = isWrite && (cnt_r == 4'(WR_END));
    wire rdSample = isRead && (cnt_r == 4'(RD_SAMPLE));
    wire rdDone = isRead && (cnt_r == 4'(RD_END));
    wire lastCmd = (step_r == seqLen(req_r.op) - 3'h1);
    wire lastByte = (idx_r == 7'h7f);
    wire toggleStill = havePrev_r &&
        (prevRead_r[`PFC_TOGGLE_BIT] == pinData[`PFC_TOGGLE_BIT]);
    wire pollTrue = (req_r.op != pfc_pkg::PFC_OP_PROGRAM) ||
        (pinData[`PFC_POLL_BIT] == lastData_r[`PFC_POLL_BIT]);
    wire pollDone = rdSample && toggleStill && pollTrue;
    wire timedOut = (tmo_r == '0);
    wire isHwId = (req_r.op == pfc_pkg::PFC_OP_HW_ID);
    wire isLockDet = (req_r.addr == `PFC_LOCK_LO_DET) || (req_r.addr == `PFC_LOCK_HI_DET);
    wire needsPoll = (req_r.op == pfc_pkg::PFC_OP_CHIP_ERASE) ||
        (req_r.op == pfc_pkg::PFC_OP_LOCK_LOW) || (req_r.op == pfc_pkg::PFC_OP_LOCK_HIGH);

    // handshakes
    assign reqReady = (state_r == S_IDLE);
    assign fillReady = (state_r == S_IDLE); // buffer frozen while a sector loads

    // ----------------------------------------
    // sector buffer
    // ----------------------------------------
    pfc_sector_mem #(
        .WIDTH(8),
        .DEPTH(`PFC_SECTOR_BYTES)
    ) u_mem (
        .ref_clk(ref_clk),
        .clkEn(clkEn),
        .wrEn(fillValid && fillReady),
        .wrAddr(fillIndex),
        .wrData(fillData),
        .rdAddr(idx_r),
        .rdData(memData)
    );

    // ----------------------------------------
    // data pin synchroniser and filter
    // ----------------------------------------
    for (genvar b = 0; b < 8; b++) begin : g_sync
        logic s1, s2, s3, f;
        // three stages, change taken when last two agree
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                {s1, s2, s3, f} <= 4'h0;
            end else if (clkEn) begin
                s1 <= dataIn[b];
                s2 <= s1;
                s3 <= s2;
                if (s2 == s3) begin
                    f <= s3;
                end
            end
        end
        assign pinData[b] = f;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (reqValid) begin
                    // reads go straight out, the rest open with commands
                    if (req.op == pfc_pkg::PFC_OP_READ || req.op == pfc_pkg::PFC_OP_HW_ID) begin
                        state_nxt = S_READ;
                    end else begin
                        state_nxt = S_CMD;
                    end
                end
            end
            S_CMD: begin
                if (wrDone && lastCmd) begin
                    if (req_r.op == pfc_pkg::PFC_OP_PROGRAM) begin
                        state_nxt = S_LOAD;
                    end else if (needsPoll) begin
                        state_nxt = S_POLL;
                    end else begin
                        state_nxt = S_RESP;
                    end
                end
            end
            S_LOAD: begin
                // all 128 bytes go in, so none falls back to ones
                if (wrDone && lastByte) begin
                    state_nxt = S_POLL;
                end
            end
            S_POLL: begin
                if (pollDone || (rdDone && timedOut)) begin
                    state_nxt = S_RESP;
                end
            end
            S_READ: begin
                if (rdDone) begin
                    state_nxt = S_RESP;
                end
            end
            S_RESP: state_nxt = S_IDLE;
            default: state_nxt = S_IDLE;
        endcase
    end

    // ----------------------------------------
    // pin drive pattern
    // ----------------------------------------
    always_comb begin
        pinsNxt = '{addr: 17'h00000, chipSelN: 1'b1, outEnN: 1'b1, writeStrobeN: 1'b1,
                    dataOut: 8'h00, dataOe: 1'b0, idHighVoltageEn: 1'b0};
        if (isWrite && cnt_r != 4'h0) begin
            // strobe low between setup and hold, enable kept high
            pinsNxt.addr = (state_r == S_LOAD) ? loadAddr : cmdWord.addr;
            pinsNxt.dataOut = (state_r == S_LOAD) ? memData : cmdWord.data;
            pinsNxt.dataOe = 1'b1;
            pinsNxt.chipSelN = 1'b0;
            pinsNxt.writeStrobeN = !(cnt_r >= 4'h2 && cnt_r < 4'(WR_END));
        end else if (isRead && cnt_r < 4'(RD_SAMPLE)) begin
            // read: strobe high, select and enable low, data lines released
            pinsNxt.addr = isHwId ? {16'h0000, req_r.addr[0]} : pollAddr;
            pinsNxt.chipSelN = 1'b0;
            pinsNxt.outEnN = 1'b0;
            pinsNxt.idHighVoltageEn = isHwId;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= S_IDLE;
            req_r <= '{op: pfc_pkg::PFC_OP_READ, addr: 17'h00000};
            cnt_r <= 4'h0;
            step_r <= 3'h0;
            idx_r <= 7'h00;
            lastData_r <= 8'h00;
            prevRead_r <= 8'h00;
            havePrev_r <= 1'b0;
            tmo_r <= '0;
            pins <= '{addr: 17'h00000, chipSelN: 1'b1, outEnN: 1'b1, writeStrobeN: 1'b1,
                      dataOut: 8'h00, dataOe: 1'b0, idHighVoltageEn: 1'b0};
            rspValid <= 1'b0;
            rsp <= '{data: 8'h00, err: 1'b0, locked: 1'b0};
        end else if (clkEn) begin
            state_r <= state_nxt;
            pins <= pinsNxt;
            rspValid <= (state_r == S_POLL || state_r == S_READ || state_r == S_CMD) &&
                        (state_nxt == S_RESP);
            if (state_r == S_IDLE && reqValid) begin
                req_r <= req;
                step_r <= 3'h0;
                idx_r <= 7'h00;
            end
            // phase counter restarts at each access end
            cnt_r <= (wrDone || rdDone || state_nxt != state_r) ? 4'h0 : cnt_r + 4'h1;
            if (state_r == S_CMD && wrDone) begin
                step_r <= step_r + 3'h1;
            end
            if (state_r == S_LOAD && wrDone) begin
                // back-to-back loads restart the device window each time
                lastData_r <= memData;
                if (!lastByte) begin
                    idx_r <= idx_r + 7'h01;
                end
            end
            if (state_nxt == S_POLL && state_r != S_POLL) begin
                havePrev_r <= 1'b0;
                tmo_r <= TW'(PROG_TIMEOUT_CYC);
            end else if (state_r == S_POLL) begin
                tmo_r <= timedOut ? tmo_r : tmo_r - TW'(1);
                if (rdSample) begin
                    prevRead_r <= pinData;
                    havePrev_r <= 1'b1;
                end
            end
            if (rdSample) begin
                rsp.data <= pinData;
                rsp.locked <= isLockDet && (pinData == `PFC_LOCK_SET);
            end
            if (state_r == S_POLL && rdDone && timedOut) begin
                rsp.err <= 1'b1;
            end else if (state_r == S_IDLE && reqValid) begin
                rsp.err <= 1'b0;
            end
        end
    end
endmodule

// [pfc_defs.svh]
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH
// ----------------------------------------
// clock and array geometry
// ----------------------------------------
`define PFC_CLK_NS 50
`define PFC_ADDR_W 17
`define PFC_SECTOR_BYTES 128
`define PFC_SECTOR_COUNT 1024
`define PFC_SECTOR_LSB 7
// ----------------------------------------
// timing figures and derived cycle counts
// ----------------------------------------
`define PFC_LOAD_WINDOW_US 150
`define PFC_LOAD_WINDOW_CYC ((`PFC_LOAD_WINDOW_US * 1000) / `PFC_CLK_NS)
`define PFC_GLITCH_NS 15
`define PFC_WE_LOW_CYC (((`PFC_GLITCH_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS) + 1)
`define PFC_ACCESS_NS 120
`define PFC_ACCESS_CYC ((`PFC_ACCESS_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_SYNC_CYC 3
`define PFC_PROG_MS 20
`define PFC_PROG_CYC ((`PFC_PROG_MS * 1000000) / `PFC_CLK_NS)
// ----------------------------------------
// boot blocks, lock detection, status bits
// ----------------------------------------
`define PFC_BOOT_LO_BASE 17'h00000
`define PFC_BOOT_HI_BASE 17'h1e000
`define PFC_LOCK_LO_DET 17'h00002
`define PFC_LOCK_HI_DET 17'h1fff2
`define PFC_LOCK_OPEN 8'hfe
`define PFC_LOCK_SET 8'hff
`define PFC_POLL_BIT 7
`define PFC_TOGGLE_BIT 6
`define PFC_ID_HV_BIT 9
`endif

// [pfc_pkg.sv]
package pfc_pkg;
    // operations the controller carries out
    typedef enum logic [2:0] {
        PFC_OP_READ,
        PFC_OP_PROGRAM,
        PFC_OP_CHIP_ERASE,
        PFC_OP_LOCK_LOW,
        PFC_OP_LOCK_HIGH,
        PFC_OP_ID_ENTRY,
        PFC_OP_ID_EXIT,
        PFC_OP_HW_ID
    } pfc_op_t;
    // user request
    typedef struct packed {
        pfc_op_t op;
        logic [16:0] addr;
    } pfc_req_t;
    // user answer
    typedef struct packed {
        logic [7:0] data;
        logic err;
        logic locked;
    } pfc_rsp_t;
    // one bus write: address and data
    typedef struct packed {
        logic [16:0] addr;
        logic [7:0] data;
    } pfc_wr_t;
    // pins driven toward the flash
    typedef struct packed {
        logic [16:0] addr;
        logic chipSelN;
        logic outEnN;
        logic writeStrobeN;
        logic [7:0] dataOut;
        logic dataOe;
        logic idHighVoltageEn;
    } pfc_pins_t;
endpackage

// [pfc_sector_mem.sv]
`include "pfc_defs.svh"
module pfc_sector_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `PFC_SECTOR_BYTES
) (
    // clock
    input wire logic ref_clk,
    input wire logic clkEn,
    // write port
    input wire logic wrEn,
    input wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // read port, data registered
    input wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    // refuse a buffer too small to address
    if (DEPTH < 2 || WIDTH < 1) begin : g_chk_depth
        $error("sector buffer shape not served");
    end
    // storage, no reset needed
    logic [WIDTH-1:0] mem [DEPTH];

    // ----------------------------------------
    // write and registered read
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (clkEn) begin
            if (wrEn) begin
                mem[wrAddr] <= wrData;
            end
            rdData <= mem[rdAddr];
        end
    end
endmodule

// [pfc_flash_host_properties.sv]
module pfc_flash_host_properties (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // request and answer
    input wire logic reqValid,
    input wire logic reqReady,
    input wire pfc_pkg::pfc_req_t req,
    input wire logic rspValid,
    input wire pfc_pkg::pfc_rsp_t rsp,
    // flash pins
    input wire pfc_pkg::pfc_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------
    // pin relations
    // ----------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // accepted read request
    wire rdTake = reqValid && reqReady && (req.op == pfc_pkg::PFC_OP_READ);
    a_idle_release: assert property ($rose(nrst) |-> pins.chipSelN && pins.writeStrobeN)
        else $error("pins not idle after reset");
    a_no_contention: assert property (pins.dataOe |-> pins.outEnN)
        else $error("data driven while read enabled");
    a_read_strobe: assert property (!pins.outEnN |-> pins.writeStrobeN && !pins.dataOe)
        else $error("strobe or data active during read");
    a_load_pins: assert property (!pins.writeStrobeN |-> !pins.chipSelN && pins.dataOe)
        else $error("load strobe without select or data");
    a_strobe_width: assert property ($fell(pins.writeStrobeN) |=> !pins.writeStrobeN)
        else $error("load strobe too short");
    a_load_steady: assert property (!pins.writeStrobeN && !$past(pins.writeStrobeN) |->
        $stable(pins.addr) && $stable(pins.dataOut)) else $error("address moved in load");
    a_hv_address: assert property (pins.idHighVoltageEn |-> pins.addr[16:1] == 16'h0000)
        else $error("upper address not low in hardware id");
    a_read_answer: assert property (rdTake |-> ##10 rspValid)
        else $error("read answer late");
    a_rsp_pulse: assert property (rspValid |=> !rspValid && reqReady)
        else $error("answer not single pulse");
    // main scenarios reached
    c_hw_id: cover property (pins.idHighVoltageEn && !pins.outEnN);
    c_locked: cover property (rspValid && rsp.locked);
    c_load: cover property ($fell(pins.writeStrobeN));
endmodule

// [pfc_flash_model.sv]
module pfc_flash_model #(
    parameter logic [16:0] CA = 17'h00aaa,
    parameter logic [16:0] CB = 17'h00555,
    parameter logic [7:0] DA = 8'h11,
    parameter logic [7:0] DB = 8'h22,
    parameter logic [7:0] CP = 8'h33,
    parameter logic [7:0] CE = 8'h44,
    parameter logic [7:0] CEF = 8'h55,
    parameter logic [7:0] CL = 8'h66,
    parameter logic [7:0] CLF = 8'h77,
    parameter logic [7:0] CI = 8'h88,
    parameter logic [7:0] CX = 8'h99,
    parameter logic [7:0] MFR = 8'h5a,
    parameter logic [7:0] DEV = 8'ha5,
    parameter int WIN = 20,
    parameter int BUSY = 300,
    parameter int PWR_DLY = 100
) (
    // timer clock
    input wire logic ref_clk,
    // pins from host
    input wire pfc_pkg::pfc_pins_t pins,
    // data lines to host
    output logic [7:0] dataLines
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------
    // device state
    // ----------------
    logic [7:0] mem [131072]; // array, erased is ones
    logic [7:0] ldBuf [int]; // sector load latches
    logic [24:0] h [7]; // last writes, newest at 6
    logic loading, idMode, lockLo, lockHi, tog, weQ, oeQ;
    logic [7:0] last, lastOut, rdVal, idVal;
    logic [9:0] sec;
    int win, busy, up; // load window, busy time, power-up age
    // read path only with select, enable low, strobe high
    wire rdOn = !pins.chipSelN && !pins.outEnN && pins.writeStrobeN;
    function automatic logic cmd(int b, logic [7:0] code);
        return h[b] == {CA, DA} && h[b + 1] == {CB, DB} && h[b + 2] == {CA, code};
    endfunction
    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
        {loading, idMode, lockLo, lockHi, tog, busy, win, up} = '0;
        {last, lastOut} = '0; // released lines start high
        {weQ, oeQ} = 2'b11;
        foreach (h[i]) h[i] = '0;
    end
    // lock codes, then device or manufacturer code
    assign idVal = (pins.addr == 17'h00002) ? (lockLo ? 8'hff : 8'hfe) :
        (pins.addr == 17'h1fff2) ? (lockHi ? 8'hff : 8'hfe) : (pins.addr[0] ? DEV : MFR);
    // reads from the program command until busy ends are status reads
    assign rdVal = (busy != 0 || loading) ? {~last[7], tog, last[5:0]} :
        (pins.idHighVoltageEn || idMode) ? idVal : mem[pins.addr];
    // released lines show the inverse of the last value
    assign dataLines = rdOn ? rdVal : ~lastOut;
    // ----------------
    // write decoding
    // ----------------
    always @(posedge ref_clk) begin
        weQ <= pins.writeStrobeN;
        oeQ <= pins.outEnN;
        if (rdOn) lastOut <= rdVal;
        if (busy > 0) busy <= busy - 1;
        // writes ignored until power-up delay ends
        if (up < PWR_DLY) up <= up + 1;
        if (!oeQ && pins.outEnN) tog <= ~tog;
        // window lapse closes loads, erase then program
        if (loading && ++win > WIN) begin
            loading = 0;
            if (!(lockLo && sec < 10'd64) && !(lockHi && sec >= 10'd960)) begin
                for (int i = 0; i < 128; i++) begin
                    mem[{sec, 7'(i)}] <= ldBuf.exists(i) ? ldBuf[i] : 8'hff;
                end
                busy <= BUSY;
            end
        end
        // data taken on rising strobe, select low, enable high
        if (!weQ && pins.writeStrobeN && !pins.chipSelN && pins.outEnN &&
            up >= PWR_DLY) begin
            if (loading) begin
                ldBuf[int'(pins.addr[6:0])] = pins.dataOut;
                sec = pins.addr[16:7];
                last <= pins.dataOut;
                win = 0;
            end else begin
                for (int i = 0; i < 6; i++) h[i] = h[i + 1];
                h[6] = {pins.addr, pins.dataOut};
                // only the command opens loading
                if (cmd(4, CP)) begin
                    loading = 1;
                    win = 0;
                    ldBuf.delete();
                end
                if (cmd(4, CI)) idMode <= 1;
                if (cmd(4, CX)) idMode <= 0;
                if (cmd(1, CE) && cmd(4, CEF) && !lockLo && !lockHi) begin
                    foreach (mem[i]) mem[i] = 8'hff;
                    busy <= BUSY;
                end
                if (cmd(0, CL) && cmd(3, CL) && h[6] == {17'h00000, CLF}) lockLo <= 1;
                if (cmd(0, CL) && cmd(3, CL) && h[6] == {17'h1e000, CLF}) lockHi <= 1;
            end
        end
    end
endmodule

// [pfc_flash_host_tb_top.sv]
module pfc_flash_host_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------
    // bench signals
    // ----------------
    localparam logic [7:0] MFR_CODE = 8'h5a; // arbitrary value
    localparam logic [7:0] DEV_CODE = 8'ha5; // arbitrary value
    logic ref_clk, nrst, clkEn, fillValid, fillReady, reqValid, reqReady, rspValid, lkLo;
    logic [6:0] fillIndex;
    logic [7:0] fillData, flashData;
    pfc_pkg::pfc_req_t req;
    pfc_pkg::pfc_rsp_t rsp, got;
    pfc_pkg::pfc_pins_t pins;
    int errors, checks_done, seed;
    int expMem[int]; // expected array, absent is ones
    pfc_flash_host #(.PROG_TIMEOUT_CYC(2000)) uut (.ref_clk(ref_clk), .nrst(nrst),
        .clkEn(clkEn), .fillValid(fillValid), .fillReady(fillReady), .fillIndex(fillIndex),
        .fillData(fillData), .reqValid(reqValid), .reqReady(reqReady), .req(req),
        .rspValid(rspValid), .rsp(rsp), .pins(pins), .dataIn(flashData));
    pfc_flash_model #(.MFR(MFR_CODE), .DEV(DEV_CODE)) flash (.ref_clk(ref_clk), .pins(pins),
        .dataLines(flashData));
    initial begin
        ref_clk = 0;
        forever #25 ref_clk = ~ref_clk;
    end
    // ----------------
    // tasks
    // ----------------
    task automatic check(string what, logic [7:0] seen, logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one request, waits for its answer
    task automatic do_req(pfc_pkg::pfc_op_t op, logic [16:0] a);
        int n;
        reqValid <= 1;
        req <= '{op, a};
        for (n = 0; n < 50; n++) begin
            @(negedge ref_clk);
            if (reqReady === 1'b1) break;
        end
        if (n >= 50) n = 9000; // never ready counts as a hang
        @(posedge ref_clk);
        reqValid <= 0;
        for (n = n; n < 9000; n++) begin
            @(negedge ref_clk);
            if (rspValid === 1'b1) break;
        end
        if (n >= 9000) begin
            errors++;
            print_verdict();
        end
        got = rsp;
        @(posedge ref_clk);
    endtask
    task automatic rdck(logic [16:0] a);
        do_req(pfc_pkg::PFC_OP_READ, a);
        check("read", got.data, expMem.exists(a) ? 8'(expMem[a]) : 8'hff);
    endtask
    // fill random bytes, program, read back ends and a random byte
    task automatic prog(logic [9:0] s);
        logic [7:0] v;
        @(negedge ref_clk);
        check("fill ready", 8'(fillReady), 8'h01);
        @(posedge ref_clk);
        for (int i = 0; i < 128; i++) begin
            v = 8'($urandom());
            fillValid <= 1;
            fillIndex <= 7'(i);
            fillData <= v;
            if (!(lkLo && s < 10'd64)) expMem[{s, 7'(i)}] = v;
            @(posedge ref_clk);
        end
        fillValid <= 0;
        do_req(pfc_pkg::PFC_OP_PROGRAM, {s, 7'h00});
        if (!(lkLo && s < 10'd64)) check("prog timeout", 8'(got.err), 8'h00);
        rdck({s, 7'h00});
        rdck({s, 7'h7f});
        rdck({s, v[6:0]});
    endtask
    // id mode look at device code and both lock bytes
    task automatic idck(logic [7:0] loLock);
        do_req(pfc_pkg::PFC_OP_ID_ENTRY, 17'h00000);
        do_req(pfc_pkg::PFC_OP_READ, 17'h00001);
        check("sw device code", got.data, DEV_CODE);
        do_req(pfc_pkg::PFC_OP_READ, 17'h00002);
        check("low lock", got.data, loLock);
        check("low lock flag", 8'(got.locked), 8'(loLock == 8'hff));
        do_req(pfc_pkg::PFC_OP_READ, 17'h1fff2);
        check("high lock", got.data, 8'hfe);
        do_req(pfc_pkg::PFC_OP_ID_EXIT, 17'h00000);
        rdck(17'h00281);
    endtask
    // ----------------
    // main sequence
    // ----------------
    initial begin
        {nrst, fillValid, fillIndex, fillData, reqValid, req, errors, checks_done, lkLo} = '0;
        clkEn = 1;
        seed = $urandom(32'h46474fcb);
        repeat (10) @(posedge ref_clk);
        nrst <= 1;
        @(posedge ref_clk);
        rdck(17'h00040);
        prog(10'd5);
        for (int k = 0; k < 2; k++) begin
            do_req(pfc_pkg::PFC_OP_HW_ID, 17'(k));
            check("hw id code", got.data, k ? DEV_CODE : MFR_CODE);
        end
        idck(8'hfe);
        do_req(pfc_pkg::PFC_OP_CHIP_ERASE, 17'h00280);
        expMem.delete();
        rdck(17'h002ff);
        prog(10'd5);
        do_req(pfc_pkg::PFC_OP_LOCK_LOW, 17'h00000);
        lkLo = 1;
        idck(8'hff);
        prog(10'd0);
        do_req(pfc_pkg::PFC_OP_CHIP_ERASE, 17'h00280);
        rdck(17'h002ff);
        rdck(17'h00280);
        print_verdict();
    end
endmodule
bind pfc_flash_host pfc_flash_host_properties chk (.ref_clk(ref_clk), .nrst(nrst),
    .reqValid(reqValid), .reqReady(reqReady), .req(req), .rspValid(rspValid), .rsp(rsp),
    .pins(pins));
